// >>> hdl/vlr_sync_pkg.sv
package vlr_sync_pkg;
   // -------------------------------------------------------------------
   // widths and frame geometry (in symbols)
   // -------------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int MULT_W = 4;
   localparam int LIM_W = CNT_W + MULT_W;
   localparam int EST_W = 16;
   localparam int BIN_W = 4;
   localparam int SEG_CNT_W = 12;
   localparam int HDR_SYMS = 90;
   localparam int KNOWN_SYMS = 64;
   localparam int ACQ_SYMS = 1476;
   localparam int PAY_SYMS = 256;
   localparam int ACQ_MIN_MATCH = 1400;
   localparam int NUM_BINS = 16;
   // symbol strobe: one symbol every SYM_DIV system clocks
   localparam int SYM_DIV = 4;
   // -------------------------------------------------------------------
   // scrambler
   // -------------------------------------------------------------------
   localparam int LFSR_W = 15;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h4a5b;
   // snr in quarter-dB steps, signed: -4 dB
   localparam logic signed [7:0] SNR_OFF_QDB = 8'hf0;

   typedef enum logic [1:0] {
      KIND_STD, KIND_VLR, KIND_VLR_DUMMY, KIND_SYNC_DUMMY
   } frame_kind_type;

   typedef enum logic [1:0] {
      SEG_HDR, SEG_KNOWN, SEG_ACQ, SEG_PAY
   } seg_type;

   typedef enum logic [1:0] {
      RX_WAIT_LOCK, RX_TRACK, RX_STEP
   } rx_state_type;

   function automatic logic [LFSR_W-1:0] lfsr_next(
      input logic [LFSR_W-1:0] s);
      lfsr_next = {s[LFSR_W-2:0], s[LFSR_W-1] ^ s[LFSR_W-2]};
   endfunction

   function automatic logic [SEG_CNT_W-1:0] seg_last(input seg_type s);
      case (s)
         SEG_HDR: seg_last = SEG_CNT_W'(HDR_SYMS - 1);
         SEG_KNOWN: seg_last = SEG_CNT_W'(KNOWN_SYMS - 1);
         SEG_ACQ: seg_last = SEG_CNT_W'(ACQ_SYMS - 1);
         default: seg_last = SEG_CNT_W'(PAY_SYMS - 1);
      endcase
   endfunction
endpackage

// >>> hdl/frame_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_link_if import vlr_sync_pkg::*; ();
   logic sym_stb;
   logic hdr_start;
   logic sym_bit;
   frame_kind_type kind;
   seg_type seg;

   modport modulator(output sym_stb, hdr_start, sym_bit, kind, seg);
   modport demodulator(input sym_stb, hdr_start, sym_bit, kind, seg);
endinterface
`default_nettype wire

// >>> hdl/vlr_modulator_end.sv
`timescale 1ns/1ps
`default_nettype none
module vlr_modulator_end import vlr_sync_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic feature_en_i,
   input wire logic sync_dummy_en_i,
   input wire logic [CNT_W-1:0] frame_n_i,
   input wire logic req_valid_i,
   input wire logic req_vlr_i,
   output logic req_ready_o,
   frame_link_if.modulator link
);
   // -------------------------------------------------------------------
   // symbol strobe divider
   // -------------------------------------------------------------------
   logic [7:0] div_ff;
   logic stb;
   assign stb = (div_ff == 8'(SYM_DIV - 1));

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= stb ? 8'h00 : div_ff + 8'h01;
      end
   end

   // -------------------------------------------------------------------
   // frame sequencer
   // -------------------------------------------------------------------
   seg_type seg_ff;
   frame_kind_type kind_ff, nxt_kind;
   logic [SEG_CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] since_ff;
   logic [LFSR_W-1:0] lfsr_ff;
   logic group_ff, nxt_group, take_req, seg_end, frame_end, first_ff;

   assign seg_end = (cnt_ff == seg_last(seg_ff));
   assign frame_end = stb && seg_end &&
      (seg_ff == SEG_PAY || seg_ff == SEG_ACQ);
   assign req_ready_o = frame_end && take_req;

   always_comb begin
      take_req = 1'b0;
      nxt_kind = KIND_STD;
      nxt_group = 1'b0;
      if (sync_dummy_en_i && req_valid_i && req_vlr_i && !group_ff) begin
         nxt_kind = KIND_SYNC_DUMMY;
         nxt_group = 1'b1;
      end else if (group_ff && req_valid_i && req_vlr_i) begin
         nxt_kind = KIND_VLR;
         nxt_group = 1'b1;
         take_req = 1'b1;
      end else if (feature_en_i && !sync_dummy_en_i &&
                   since_ff >= frame_n_i) begin
         nxt_kind = KIND_VLR_DUMMY;
      end else if (req_valid_i) begin
         nxt_kind = req_vlr_i ? KIND_VLR : KIND_STD;
         take_req = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seg_ff <= SEG_HDR;
         cnt_ff <= '0;
      end else if (stb) begin
         if (!seg_end) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else begin
            cnt_ff <= '0;
            case (seg_ff)
               SEG_HDR: begin
                  // header, known block, acquisition header
                  seg_ff <= (kind_ff == KIND_SYNC_DUMMY) ?
                     SEG_KNOWN : SEG_PAY;
               end
               SEG_KNOWN: seg_ff <= SEG_ACQ;
               default: seg_ff <= SEG_HDR;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         kind_ff <= KIND_STD;
         group_ff <= 1'b0;
      end else if (frame_end) begin
         kind_ff <= nxt_kind;
         group_ff <= nxt_group;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         since_ff <= '0;
      end else if (frame_end) begin
         if (nxt_kind == KIND_VLR || nxt_kind == KIND_VLR_DUMMY) begin
            since_ff <= '0;
         end else if (since_ff != '1) begin
            since_ff <= since_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr_ff <= LFSR_SEED;
      end else if (frame_end) begin
         lfsr_ff <= LFSR_SEED;
      end else if (stb) begin
         lfsr_ff <= lfsr_next(lfsr_ff);
      end
   end

   // -------------------------------------------------------------------
   // registered link outputs: one symbol per strobe
   // -------------------------------------------------------------------
   logic stb_ff, hs_ff, bit_ff, scr;
   frame_kind_type okind_ff;
   seg_type oseg_ff;

   // flat pseudo-random fill of standard dummies keeps them from looking
   // like the long acquisition header to other correlators
   assign scr = (kind_ff == KIND_SYNC_DUMMY) ||
      (sync_dummy_en_i && kind_ff == KIND_STD && seg_ff == SEG_PAY &&
       !first_ff);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_ff <= 1'b1;
      end else if (frame_end) begin
         first_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stb_ff <= 1'b0;
         hs_ff <= 1'b0;
         bit_ff <= 1'b0;
         okind_ff <= KIND_STD;
         oseg_ff <= SEG_HDR;
      end else begin
         stb_ff <= stb;
         if (stb) begin
            hs_ff <= (seg_ff == SEG_HDR) && (cnt_ff == '0);
            bit_ff <= scr & lfsr_ff[0];
            okind_ff <= kind_ff;
            oseg_ff <= seg_ff;
         end
      end
   end

   assign link.sym_stb = stb_ff;
   assign link.hdr_start = stb_ff & hs_ff;
   assign link.sym_bit = bit_ff;
   assign link.kind = okind_ff;
   assign link.seg = oseg_ff;
endmodule
`default_nettype wire

// >>> hdl/vlr_demodulator_end.sv
// Contract
// - tx inserts low-ratio dummy after n plain frames
// - rx reacquires when locked but nothing seen
// - step search dwells multiple of n frames
// - step to next bin on dwell timeout
// - header correlator off below -4 dB
// - header detections update carrier, rate, timing estimates
// - sync dummy: header, known block, acquisition header
// - acquisition header is exactly 1476 symbols
// - sync dummy waveform is scrambled
// - detect low-ratio headers or skip their containers
// - sync dummy precedes each back-to-back low-ratio group
// - sync dummy carriers: no low-ratio dummies, random fill (tx sends zeros in the payload of the first frame after reset)
`timescale 1ns/1ps
`default_nettype none
module vlr_demodulator_end import vlr_sync_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic step_mode_i,
   input wire logic vlr_support_i,
   input wire logic freq_locked_i,
   input wire logic [CNT_W-1:0] frame_n_i,
   input wire logic [MULT_W-1:0] timeout_mult_i,
   input wire logic [MULT_W-1:0] dwell_mult_i,
   input wire logic signed [7:0] snr_qdb_i,
   input wire logic det_valid_i,
   input wire logic [EST_W-1:0] det_carrier_i,
   input wire logic [EST_W-1:0] det_rate_i,
   input wire logic [EST_W-1:0] det_timing_i,
   output logic reacq_o,
   output logic bin_step_o,
   output logic [BIN_W-1:0] bin_o,
   output logic corr_en_o,
   output logic [EST_W-1:0] carrier_est_o,
   output logic [EST_W-1:0] rate_est_o,
   output logic [EST_W-1:0] timing_est_o,
   output logic vlr_det_o,
   output logic sync_lock_o,
   output logic skip_o,
   output logic [1:0] state_o,
   frame_link_if.demodulator link
);
   // -------------------------------------------------------------------
   // header classification
   // -------------------------------------------------------------------
   logic vlr_hdr, hdr_seen;
   frame_kind_type kind_ff;
   logic skip_ff, vdet_ff;

   assign hdr_seen = link.sym_stb && link.hdr_start;
   assign vlr_hdr = hdr_seen &&
      (link.kind == KIND_VLR || link.kind == KIND_VLR_DUMMY);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         kind_ff <= KIND_STD;
         skip_ff <= 1'b0;
         vdet_ff <= 1'b0;
      end else begin
         vdet_ff <= vlr_hdr && vlr_support_i;
         if (hdr_seen) begin
            kind_ff <= link.kind;
            // without support the whole container is passed over
            skip_ff <= vlr_hdr && !vlr_support_i;
         end
      end
   end

   assign vlr_det_o = vdet_ff;
   assign skip_o = skip_ff;

   // -------------------------------------------------------------------
   // long acquisition header correlation
   // -------------------------------------------------------------------
   logic [LFSR_W-1:0] lfsr_ff;
   logic [SEG_CNT_W-1:0] acq_cnt_ff, match_ff, match_now;
   logic exp_bit, acq_sym, acq_last, lock_ff;

   // the scrambler restarts with every frame, as on the sending side
   assign exp_bit = link.hdr_start ? LFSR_SEED[0] : lfsr_ff[0];
   assign acq_sym = link.sym_stb && !link.hdr_start &&
      link.seg == SEG_ACQ && kind_ff == KIND_SYNC_DUMMY;
   assign acq_last = acq_sym &&
      acq_cnt_ff == SEG_CNT_W'(ACQ_SYMS - 1);
   assign match_now = match_ff +
      SEG_CNT_W'(link.sym_bit == exp_bit);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr_ff <= LFSR_SEED;
      end else if (link.sym_stb) begin
         lfsr_ff <= lfsr_next(link.hdr_start ? LFSR_SEED : lfsr_ff);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acq_cnt_ff <= '0;
         match_ff <= '0;
         lock_ff <= 1'b0;
      end else begin
         lock_ff <= acq_last &&
            match_now >= SEG_CNT_W'(ACQ_MIN_MATCH);
         if (hdr_seen) begin
            acq_cnt_ff <= '0;
            match_ff <= '0;
         end else if (acq_sym) begin
            acq_cnt_ff <= acq_cnt_ff + 1'b1;
            match_ff <= match_now;
         end
      end
   end

   assign sync_lock_o = lock_ff;

   // -------------------------------------------------------------------
   // frame-count timer
   // -------------------------------------------------------------------
   logic [LIM_W-1:0] frm_ff, timeout_lim, dwell_lim;
   logic found, tmo_hit, dwell_hit, clr;
   rx_state_type state_ff;

   // a sync dummy lock counts as a sighting as well
   assign found = (vlr_hdr && vlr_support_i) || lock_ff;
   assign timeout_lim = LIM_W'(frame_n_i * timeout_mult_i);
   assign dwell_lim = LIM_W'(frame_n_i * dwell_mult_i);
   assign tmo_hit = !found && frm_ff >= timeout_lim;
   assign dwell_hit = !found && frm_ff >= dwell_lim;
   assign clr = found ||
      (state_ff == RX_TRACK && tmo_hit) ||
      (state_ff == RX_STEP && dwell_hit) ||
      (state_ff == RX_WAIT_LOCK);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         frm_ff <= '0;
      end else if (clr) begin
         frm_ff <= '0;
      end else if (hdr_seen && frm_ff != '1) begin
         frm_ff <= frm_ff + 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // acquisition supervisor
   // -------------------------------------------------------------------
   logic reacq_ff, step_ff;
   logic [BIN_W-1:0] bin_ff, bin_inc;

   assign bin_inc = (bin_ff == BIN_W'(NUM_BINS - 1)) ?
      '0 : bin_ff + 1'b1;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= RX_WAIT_LOCK;
         reacq_ff <= 1'b0;
         step_ff <= 1'b0;
         bin_ff <= '0;
      end else begin
         reacq_ff <= 1'b0;
         step_ff <= 1'b0;
         case (state_ff)
            RX_WAIT_LOCK: begin
               if (step_mode_i) begin
                  state_ff <= RX_STEP;
               end else if (freq_locked_i) begin
                  state_ff <= RX_TRACK;
               end
            end
            RX_TRACK: begin
               if (tmo_hit) begin
                  if (step_mode_i) begin
                     state_ff <= RX_STEP;
                     bin_ff <= bin_inc;
                     step_ff <= 1'b1;
                  end else begin
                     // likely locked to a neighbour carrier
                     state_ff <= RX_WAIT_LOCK;
                     reacq_ff <= 1'b1;
                  end
               end
            end
            RX_STEP: begin
               if (!step_mode_i) begin
                  state_ff <= RX_WAIT_LOCK;
               end else if (found) begin
                  state_ff <= RX_TRACK;
               end else if (dwell_hit) begin
                  bin_ff <= bin_inc;
                  step_ff <= 1'b1;
               end
            end
            default: state_ff <= RX_WAIT_LOCK;
         endcase
      end
   end

   assign reacq_o = reacq_ff;
   assign bin_step_o = step_ff;
   assign bin_o = bin_ff;
   assign state_o = state_ff;

   // -------------------------------------------------------------------
   // header correlator gate and header loop
   // -------------------------------------------------------------------
   logic corr_ff;
   logic [EST_W-1:0] car_ff, rate_ff, tim_ff;

   // equal to the threshold keeps the old state: a little hysteresis
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         corr_ff <= 1'b0;
      end else if (snr_qdb_i < SNR_OFF_QDB) begin
         corr_ff <= 1'b0;
      end else if (snr_qdb_i > SNR_OFF_QDB) begin
         corr_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         car_ff <= '0;
         rate_ff <= '0;
         tim_ff <= '0;
      end else if (det_valid_i && corr_ff) begin
         car_ff <= det_carrier_i;
         rate_ff <= det_rate_i;
         tim_ff <= det_timing_i;
      end
   end

   assign corr_en_o = corr_ff;
   assign carrier_est_o = car_ff;
   assign rate_est_o = rate_ff;
   assign timing_est_o = tim_ff;
endmodule
`default_nettype wire

// >>> bench/vlr_sync_props.sv
`timescale 1ns/1ps
`default_nettype none
module vlr_sync_props import vlr_sync_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic sym_stb,
   input wire logic hdr_start,
   input wire logic sym_bit,
   input wire frame_kind_type kind,
   input wire seg_type seg
);
   // ---------------------------------------------------------------
   // helper state: segment run length and reference scrambler
   // ---------------------------------------------------------------
   logic [SEG_CNT_W-1:0] run_ff;
   seg_type last_ff;
   logic [LFSR_W-1:0] scr_ff;
   logic seg_end;
   logic exp_bit;

   function automatic logic [LFSR_W-1:0] scr_adv(
      input logic [LFSR_W-1:0] s);
      return {s[LFSR_W-2:0], s[LFSR_W-1] ^ s[LFSR_W-2]};
   endfunction

   // run_ff of zero marks "no segment seen yet" after reset
   assign seg_end = sym_stb && (hdr_start || seg != last_ff) && run_ff != '0;
   assign exp_bit = hdr_start ? LFSR_SEED[0] : scr_ff[0];

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_ff <= '0;
         last_ff <= SEG_HDR;
      end else if (sym_stb) begin
         last_ff <= seg;
         if (hdr_start || seg != last_ff) begin
            run_ff <= SEG_CNT_W'(1);
         end else begin
            run_ff <= run_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scr_ff <= LFSR_SEED;
      end else if (sym_stb) begin
         scr_ff <= scr_adv(hdr_start ? LFSR_SEED : scr_ff);
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence sym_gap_s;
      !sym_stb [*3] ##1 sym_stb;
   endsequence
   sequence new_seg_s;
      sym_stb && seg != last_ff && !hdr_start && run_ff != '0;
   endsequence

   stb_gap_a: assert property (sym_stb |=> sym_gap_s)
      else $error("symbol strobe spacing wrong");
   hdr_on_stb_a: assert property (
      hdr_start |-> sym_stb && seg == SEG_HDR)
      else $error("frame start off a header symbol");
   hdr_len_a: assert property (seg_end && last_ff == SEG_HDR |->
      run_ff == SEG_CNT_W'(HDR_SYMS)) else $error("header length wrong");
   acq_len_a: assert property (seg_end && last_ff == SEG_ACQ |->
      run_ff == SEG_CNT_W'(ACQ_SYMS)) else $error("acquisition length wrong");
   seg_order_a: assert property (new_seg_s |->
      (seg == SEG_KNOWN && last_ff == SEG_HDR) ||
      (seg == SEG_ACQ && last_ff == SEG_KNOWN) ||
      (seg == SEG_PAY && last_ff == SEG_HDR)) else $error("segment order");
   frame_end_a: assert property (hdr_start && run_ff != '0 |->
      last_ff == SEG_PAY || last_ff == SEG_ACQ) else $error("frame cut short");
   kind_hold_a: assert property (
      sym_stb && !hdr_start |-> $stable(kind))
      else $error("frame kind changed inside a frame");
   sync_shape_a: assert property (
      sym_stb && kind == KIND_SYNC_DUMMY |-> seg != SEG_PAY)
      else $error("payload inside sync dummy");
   sync_scram_a: assert property (
      sym_stb && kind == KIND_SYNC_DUMMY |-> sym_bit == exp_bit)
      else $error("sync dummy not scrambled");
endmodule
`default_nettype wire

// >>> bench/very_low_snr_sync_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp, msg) begin total_checks++; if ((act) !== (exp)) begin \
   num_errors++; $display("MISMATCH %0t %s", $time, msg); end end
module very_low_snr_sync_supervisor_tb_top import vlr_sync_pkg::*;;
   logic sys_clk_i = 0, rst_i = 1, feature_en = 0, sdum_en = 0;
   logic req_valid = 0, req_vlr = 0, step_mode = 0, vlr_support = 1;
   logic freq_locked = 0, det_valid = 0;
   logic [CNT_W-1:0] frame_n = 16'h0002;
   logic [MULT_W-1:0] tmo_mult = 4'h3, dwell_mult = 4'h1;
   logic signed [7:0] snr = 8'hec;
   logic [EST_W-1:0] det_c = '0, det_r = '0, det_t = '0;
   logic req_ready_o, reacq_o, bin_step_o, corr_en_o, vlr_det_o;
   logic sync_lock_o, skip_o;
   logic [BIN_W-1:0] bin_o;
   logic [EST_W-1:0] car_o, rate_o, tim_o;
   logic [1:0] state_o;
   int num_errors = 0, total_checks = 0;
   localparam frame_kind_type GRP_K [6] = '{KIND_STD, KIND_SYNC_DUMMY,
      KIND_VLR, KIND_VLR, KIND_STD, KIND_STD};

   frame_link_if link();
   vlr_modulator_end u_vlr_modulator_end(.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .feature_en_i(feature_en), .sync_dummy_en_i(sdum_en),
      .frame_n_i(frame_n), .req_valid_i(req_valid), .req_vlr_i(req_vlr),
      .req_ready_o(req_ready_o), .link(link));
   vlr_demodulator_end u_vlr_demodulator_end(.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .step_mode_i(step_mode), .vlr_support_i(vlr_support),
      .freq_locked_i(freq_locked), .frame_n_i(frame_n),
      .timeout_mult_i(tmo_mult), .dwell_mult_i(dwell_mult),
      .snr_qdb_i(snr), .det_valid_i(det_valid), .det_carrier_i(det_c),
      .det_rate_i(det_r), .det_timing_i(det_t), .reacq_o(reacq_o),
      .bin_step_o(bin_step_o), .bin_o(bin_o), .corr_en_o(corr_en_o),
      .carrier_est_o(car_o), .rate_est_o(rate_o), .timing_est_o(tim_o),
      .vlr_det_o(vlr_det_o), .sync_lock_o(sync_lock_o), .skip_o(skip_o),
      .state_o(state_o), .link(link));
   vlr_sync_props u_vlr_sync_props(.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .sym_stb(link.sym_stb), .hdr_start(link.hdr_start),
      .sym_bit(link.sym_bit), .kind(link.kind), .seg(link.seg));

   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // ---------------------------------------------------------------
   // shared tasks; everything samples and drives at the falling edge
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic do_reset();
      rst_i = 1;
      tick(8);
      rst_i = 0;
      tick(1);
   endtask
   // longest frame is 1630 symbols, 6520 clocks
   task automatic wait_hdr(output frame_kind_type k);
      int i;
      for (i = 0; i < 7000; i++) begin
         @(negedge sys_clk_i);
         if (link.hdr_start === 1'b1) break;
      end
      if (i == 7000) begin
         num_errors++;
         $display("MISMATCH %0t no frame start", $time);
         stop_test();
      end else k = link.kind;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_corr();
      do_reset();
      tick(2);
      `CHK(corr_en_o, 1'b0, "correlator on at low snr")
      det_c = 16'h1234; det_r = 16'h5678; det_t = 16'h9abc; det_valid = 1;
      tick(1);
      det_valid = 0;
      tick(2);
      `CHK(car_o, 16'h0000, "detection taken while off")
      snr = 8'hf0;
      tick(2);
      `CHK(corr_en_o, 1'b0, "threshold did not hold")
      snr = 8'hf6;
      tick(2);
      `CHK(corr_en_o, 1'b1, "correlator not enabled")
      det_c = 16'h0f1e; det_r = 16'h2d3c; det_t = 16'h4b5a; det_valid = 1;
      tick(1);
      det_valid = 0;
      tick(2);
      `CHK(car_o, 16'h0f1e, "carrier estimate")
      `CHK(rate_o, 16'h2d3c, "rate estimate")
      `CHK(tim_o, 16'h4b5a, "timing estimate")
      snr = 8'hef;
      tick(2);
      `CHK(corr_en_o, 1'b0, "correlator not disabled")
      $display("test corr done");
   endtask

   task automatic t_dummy();
      frame_kind_type k;
      int i, plain;
      feature_en = 1; frame_n = 16'h0002; vlr_support = 0;
      do_reset();
      for (i = 0; i < 6; i++) begin
         wait_hdr(k);
         if (k == KIND_VLR_DUMMY) break;
      end
      `CHK(k, KIND_VLR_DUMMY, "no low-ratio dummy")
      tick(2);
      `CHK(skip_o, 1'b1, "container not skipped")
      plain = 0;
      for (i = 0; i < 6; i++) begin
         wait_hdr(k);
         if (k == KIND_VLR_DUMMY) break;
         plain++;
      end
      tick(1);
      `CHK(plain, 2, "dummy spacing")
      `CHK(vlr_det_o, 1'b0, "detected without support")
      $display("test dummy done");
   endtask

   task automatic t_group();
      frame_kind_type seen [6];
      int i, nk, takes;
      logic lock_seen, det_seen, drop;
      // low-ratio dummies stay enabled: the sync carrier must suppress them
      feature_en = 1;
      sdum_en = 1;
      frame_n = 16'h0001;
      vlr_support = 1;
      do_reset();
      req_vlr = 1; req_valid = 1;
      nk = 0; takes = 0; lock_seen = 0; det_seen = 0; drop = 0;
      for (i = 0; i < 16000 && nk < 6; i++) begin
         @(negedge sys_clk_i);
         if (drop) req_valid = 0;
         drop = 0;
         if (req_ready_o === 1'b1) begin
            takes++;
            drop = (takes == 2);
         end
         if (link.hdr_start === 1'b1) begin
            seen[nk] = link.kind;
            nk++;
         end
         if (sync_lock_o === 1'b1) lock_seen = 1;
         if (vlr_det_o === 1'b1) det_seen = 1;
      end
      `CHK(nk, 6, "too few frames")
      for (i = 0; i < nk; i++) begin
         `CHK(seen[i], GRP_K[i], "group order")
      end
      `CHK(takes, 2, "requests taken")
      `CHK(lock_seen, 1'b1, "no lock on sync dummy")
      `CHK(det_seen, 1'b1, "low-ratio frame missed")
      $display("test group done");
   endtask

   task automatic t_timeout();
      frame_kind_type k;
      int i, n_hdr;
      logic re_seen;
      feature_en = 0; sdum_en = 0; frame_n = 16'h0002; tmo_mult = 4'h3;
      do_reset();
      wait_hdr(k);
      freq_locked = 1; n_hdr = 0;
      for (i = 0; i < 12000; i++) begin
         @(negedge sys_clk_i);
         if (link.hdr_start === 1'b1) n_hdr++;
         if (reacq_o === 1'b1) break;
      end
      `CHK(reacq_o, 1'b1, "no reacquisition")
      `CHK(n_hdr, 6, "timeout length")
      // with a dummy after every two plain frames the timer never runs out
      feature_en = 1; n_hdr = 0; re_seen = 0;
      for (i = 0; i < 13000 && n_hdr < 8; i++) begin
         @(negedge sys_clk_i);
         if (link.hdr_start === 1'b1) n_hdr++;
         if (reacq_o === 1'b1) re_seen = 1;
      end
      `CHK(re_seen, 1'b0, "timer not restarted")
      $display("test timeout done");
   endtask

   task automatic t_step();
      int i, steps, n_hdr, bad;
      logic [BIN_W-1:0] exp_bin;
      feature_en = 0; freq_locked = 0; step_mode = 1; frame_n = 16'h0001;
      do_reset();
      tick(2);
      `CHK(state_o, 2'h2, "not in step search")
      steps = 0; n_hdr = 0; bad = 0; exp_bin = 4'h0;
      for (i = 0; i < 26000 && steps < 17; i++) begin
         @(negedge sys_clk_i);
         if (link.hdr_start === 1'b1) n_hdr++;
         if (bin_step_o === 1'b1) begin
            steps++;
            exp_bin = exp_bin + 4'h1;
            if (steps > 1 && n_hdr != 1) bad++;
            n_hdr = 0;
            tick(1);
            `CHK(bin_o, exp_bin, "bin sequence")
         end
      end
      `CHK(steps, 17, "bin steps missing")
      `CHK(bad, 0, "dwell length")
      $display("test step done");
   endtask

   initial begin
      t_corr();
      t_dummy();
      t_group();
      t_timeout();
      t_step();
      stop_test();
   end
endmodule
`default_nettype wire
